/* dss_consts.svh */
// constants for the disk seek and sector sequencer
`ifndef DSS_CONSTS_SVH
`define DSS_CONSTS_SVH
`define DSS_CLK_MHZ 125
`define DSS_SETTLE_MS 15
`define DSS_SETTLE_CYC (`DSS_SETTLE_MS * 1000 * `DSS_CLK_MHZ)
`define DSS_RATE_MS0 3
`define DSS_RATE_MS1 6
`define DSS_RATE_MS2 10
`define DSS_RATE_MS3 15
`define DSS_PULSE_US 4
`define DSS_PULSE_CYC (`DSS_PULSE_US * `DSS_CLK_MHZ)
`define DSS_RESTORE_MAX 8'hFF
`define DSS_TRACK_MAX 8'h4C
`define DSS_REV_LIMIT 3'h4
`define DSS_SIDE_LIMIT 3'h5
`define DSS_DAM_SD 6'h1E
`define DSS_DAM_DD 6'h2B
`define DSS_SPT 8'h1A
`define DSS_MR_CMD 8'h03
`define DSS_ST_LOST 2
`define DSS_ST_CRC 3
`define DSS_ST_SEEK 4
`define DSS_ST_DEL 5
`define DSS_ST_NRDY 7
`endif

/* dss_pkg.sv */
// types for the disk seek and sector sequencer
package dss_pkg;
  typedef enum logic [3:0] {
    DS_IDLE, DS_DECIDE, DS_PULSE, DS_RATE, DS_POST, DS_SETTLE,
    DS_HWAIT, DS_VERIFY, DS_IDSRCH, DS_DAM, DS_DATA
  } dss_state_t;
endpackage : dss_pkg

/* dss_sequencer.sv */
// disk seek and sector sequencer core
// Functional notes
// - verify: load head, wait 15 ms, wait head settled, read first ID
// - verify match with good CRC: interrupt, clear busy
// - verify mismatch with good CRC: interrupt, seek error, clear busy
// - verify match with bad CRC: set CRC error, try next ID
// - verify without good ID in four revolutions: abort with interrupt
// - step commands change track register only when update flag set
// - restore steps until track zero low, then clears track, interrupts
// - restore gives up after 255 pulses with seek error
// - master reset release runs a restore
// - seek steps toward data register, updating track until equal
// - step repeats previous direction, waits rate, verifies when verify flag set, interrupts
// - step-in toward track 76, step-out toward track 0
// - sector command sets busy, loads head, optional 15 ms settle
// - ID search compares track then sector, needs good ID CRC
// - no matching ID in four revolutions sets record not found
// - multi-sector advances sector until past track end or forced stop
// - side compare against side flag, five index pulses limit
// - side select output follows side flag at sector command start
// - data mark within 30 or 43 bytes else record not found
// - each assembled byte goes to holding register with byte request
// - overwritten unread byte sets lost data
// - bad data CRC sets CRC error and ends command
// - completion raises interrupt and clears busy
// - sector command without drive ready interrupts, not executed
// - deleted data mark recorded in status bit 5
`timescale 1ns/1ps
`default_nettype none
`include "dss_consts.svh"
module dss_sequencer import dss_pkg::*; #(
  parameter int SETTLE_CYC = `DSS_SETTLE_CYC,
  parameter int RATE_CYC0 = `DSS_RATE_MS0 * 1000 * `DSS_CLK_MHZ,
  parameter int RATE_CYC1 = `DSS_RATE_MS1 * 1000 * `DSS_CLK_MHZ,
  parameter int RATE_CYC2 = `DSS_RATE_MS2 * 1000 * `DSS_CLK_MHZ,
  parameter int RATE_CYC3 = `DSS_RATE_MS3 * 1000 * `DSS_CLK_MHZ,
  parameter bit SIDE_OUT_VARIANT = 1'b0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic master_reset_n,
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_in,
  input wire logic track_wr,
  input wire logic sector_wr,
  input wire logic data_wr,
  input wire logic [7:0] wr_data,
  input wire logic data_rd,
  input wire logic drive_ready,
  input wire logic track_zero_in,
  input wire logic head_settled_in,
  input wire logic index_pulse,
  input wire logic double_density,
  input wire logic byte_tick,
  input wire logic id_valid,
  input wire logic [7:0] id_track,
  input wire logic [7:0] id_side,
  input wire logic [7:0] id_sector,
  input wire logic [1:0] id_len,
  input wire logic id_crc_ok,
  input wire logic dam_valid,
  input wire logic dam_deleted,
  input wire logic rd_valid,
  input wire logic [7:0] rd_byte,
  input wire logic data_end,
  input wire logic data_crc_ok,
  output logic busy,
  output logic completion_irq,
  output logic byte_request,
  output logic [7:0] status,
  output logic [7:0] track_reg,
  output logic [7:0] sector_reg,
  output logic [7:0] data_reg,
  output logic [7:0] data_holding_reg,
  output logic step_out,
  output logic dir_out,
  output logic head_load_out,
  output logic side_select_out
);
  // ************************************************
  // decode helpers
  // ************************************************
  function automatic logic is_type1(input logic [7:0] c);
    return c[7] == 1'b0;
  endfunction : is_type1

  function automatic logic [21:0] rate_cyc(input logic [1:0] r);
    case (r)
      2'h0: return 22'(RATE_CYC0);
      2'h1: return 22'(RATE_CYC1);
      2'h2: return 22'(RATE_CYC2);
      default: return 22'(RATE_CYC3);
    endcase
  endfunction : rate_cyc

  // ************************************************
  // state
  // ************************************************
  dss_state_t st_r, st_nxt;
  logic [7:0] cmd_r, cmd_nxt, trk_r, trk_nxt, sec_r, sec_nxt, dat_r, dat_nxt;
  logic [7:0] dh_r, dh_nxt, steps_r, steps_nxt;
  logic [7:2] stat_r, stat_nxt;
  logic busy_r, busy_nxt, irq_r, irq_nxt, drq_r, drq_nxt;
  logic step_r, step_nxt, dir_r, dir_nxt, hld_r, hld_nxt, sso_r, sso_nxt;
  logic side_seen_r, side_seen_nxt, mrn_r;
  logic [21:0] cnt_r, cnt_nxt;
  logic [2:0] idx_r, idx_nxt;
  logic [10:0] bytes_r, bytes_nxt;
  logic [5:0] gap_r, gap_nxt;
  logic side_ok, trk_ok, sec_ok, do_start;
  logic [7:0] start_cmd;

  always_comb begin
    do_start = 1'b0;
    start_cmd = cmd_in;
    st_nxt = st_r;
    cmd_nxt = cmd_r;
    trk_nxt = track_wr ? wr_data : trk_r;
    sec_nxt = sector_wr ? wr_data : sec_r;
    dat_nxt = data_wr ? wr_data : dat_r;
    dh_nxt = dh_r;
    steps_nxt = steps_r;
    stat_nxt = stat_r;
    busy_nxt = busy_r;
    irq_nxt = irq_r;
    drq_nxt = drq_r && !data_rd;
    step_nxt = step_r;
    dir_nxt = dir_r;
    hld_nxt = hld_r;
    sso_nxt = sso_r;
    side_seen_nxt = side_seen_r;
    cnt_nxt = (cnt_r != 22'h0) ? cnt_r - 22'h1 : cnt_r;
    idx_nxt = idx_r;
    bytes_nxt = bytes_r;
    gap_nxt = gap_r;
    trk_ok = id_track == trk_r;
    sec_ok = id_sector == sec_r;
    // the 'b' variant drives the side pin instead of comparing
    side_ok = SIDE_OUT_VARIANT || !cmd_r[1] || (id_side[0] == cmd_r[3]);
    if (master_reset_n && !mrn_r) begin
      do_start = 1'b1;
      start_cmd = `DSS_MR_CMD;
    end else if (cmd_wr && master_reset_n) begin
      do_start = 1'b1;
    end
    if (!master_reset_n) begin
      st_nxt = DS_IDLE;
      busy_nxt = 1'b0;
      step_nxt = 1'b0;
    end else if (do_start && start_cmd[7:4] == 4'hD) begin
      // force interrupt: status bits kept, busy dropped
      st_nxt = DS_IDLE;
      busy_nxt = 1'b0;
      step_nxt = 1'b0;
      irq_nxt = start_cmd[3:0] != 4'h0;
    end else if (do_start && !busy_r) begin
      cmd_nxt = start_cmd;
      irq_nxt = 1'b0;
      stat_nxt = '0;
      drq_nxt = 1'b0;
      steps_nxt = 8'h0;
      idx_nxt = 3'h0;
      side_seen_nxt = 1'b0;
      if (is_type1(start_cmd)) begin
        busy_nxt = 1'b1;
        hld_nxt = start_cmd[3];
        st_nxt = DS_DECIDE;
      end else if (start_cmd[7:5] == 3'b100 && drive_ready) begin
        busy_nxt = 1'b1;
        hld_nxt = 1'b1;
        if (SIDE_OUT_VARIANT) sso_nxt = start_cmd[1];
        cnt_nxt = 22'(SETTLE_CYC);
        st_nxt = start_cmd[2] ? DS_SETTLE : DS_HWAIT;
      end else begin
        // not ready, or a command this sequencer does not run
        stat_nxt[`DSS_ST_NRDY] = !drive_ready;
        irq_nxt = 1'b1;
      end
    end else begin
      case (st_r)
        DS_IDLE: begin
        end
        DS_DECIDE: begin
          if (cmd_r[7:4] == 4'h0) begin
            if (!track_zero_in) begin
              trk_nxt = 8'h0;
              st_nxt = DS_POST;
            end else if (steps_r == `DSS_RESTORE_MAX) begin
              stat_nxt[`DSS_ST_SEEK] = 1'b1;
              busy_nxt = 1'b0;
              irq_nxt = 1'b1;
              st_nxt = DS_IDLE;
            end else begin
              dir_nxt = 1'b0;
              st_nxt = DS_PULSE;
            end
          end else if (cmd_r[7:4] == 4'h1) begin
            if (trk_r == dat_r) begin
              st_nxt = DS_POST;
            end else begin
              dir_nxt = dat_r > trk_r;
              trk_nxt = (dat_r > trk_r) ? trk_r + 8'h1 : trk_r - 8'h1;
              st_nxt = DS_PULSE;
            end
          end else begin
            if (cmd_r[6:5] == 2'b10) dir_nxt = 1'b1;
            if (cmd_r[6:5] == 2'b11) dir_nxt = 1'b0;
            // plain step keeps dir_r from the previous step
            if (cmd_r[4]) begin
              if (cmd_r[6:5] == 2'b01) begin
                trk_nxt = dir_r ? trk_r + 8'h1 : trk_r - 8'h1;
              end else begin
                trk_nxt = cmd_r[5] ? trk_r - 8'h1 : trk_r + 8'h1;
              end
            end
            st_nxt = DS_PULSE;
          end
          cnt_nxt = 22'(`DSS_PULSE_CYC);
          step_nxt = (st_nxt == DS_PULSE);
        end
        DS_PULSE: begin
          if (cnt_r == 22'h1) begin
            step_nxt = 1'b0;
            steps_nxt = steps_r + 8'h1;
            cnt_nxt = rate_cyc(cmd_r[1:0]);
            st_nxt = DS_RATE;
          end
        end
        DS_RATE: begin
          if (cnt_r == 22'h1) begin
            st_nxt = (cmd_r[7:5] == 3'b000) ? DS_DECIDE : DS_POST;
          end
        end
        DS_POST: begin
          if (cmd_r[2]) begin
            hld_nxt = 1'b1;
            cnt_nxt = 22'(SETTLE_CYC);
            st_nxt = DS_SETTLE;
          end else begin
            busy_nxt = 1'b0;
            irq_nxt = 1'b1;
            st_nxt = DS_IDLE;
          end
        end
        DS_SETTLE: begin
          if (cnt_r <= 22'h1) st_nxt = DS_HWAIT;
        end
        DS_HWAIT: begin
          if (head_settled_in) begin
            idx_nxt = 3'h0;
            st_nxt = is_type1(cmd_r) ? DS_VERIFY : DS_IDSRCH;
          end
        end
        DS_VERIFY: begin
          if (id_valid && id_crc_ok) begin
            stat_nxt[`DSS_ST_SEEK] = !trk_ok;
            busy_nxt = 1'b0;
            irq_nxt = 1'b1;
            st_nxt = DS_IDLE;
          end else begin
            // a bad ID may share its cycle with the index; the limit must still end the wait
            if (id_valid && trk_ok) stat_nxt[`DSS_ST_CRC] = 1'b1;
            if (index_pulse && idx_r == `DSS_REV_LIMIT - 3'h1) begin
              busy_nxt = 1'b0;
              irq_nxt = 1'b1;
              st_nxt = DS_IDLE;
            end
          end
          if (index_pulse) idx_nxt = idx_r + 3'h1;
        end
        DS_IDSRCH: begin
          if (index_pulse) idx_nxt = idx_r + 3'h1;
          if (id_valid && side_ok) side_seen_nxt = 1'b1;
          if (id_valid && trk_ok && sec_ok && side_ok && id_crc_ok) begin
            bytes_nxt = 11'h080 << id_len;
            gap_nxt = 6'h0;
            st_nxt = DS_DAM;
          end else if (index_pulse && (idx_nxt == `DSS_SIDE_LIMIT
              || (idx_nxt == `DSS_REV_LIMIT && (side_seen_nxt || !cmd_r[1])))) begin
            stat_nxt[`DSS_ST_SEEK] = 1'b1;
            busy_nxt = 1'b0;
            irq_nxt = 1'b1;
            st_nxt = DS_IDLE;
          end
        end
        DS_DAM: begin
          if (dam_valid) begin
            stat_nxt[`DSS_ST_DEL] = dam_deleted;
            st_nxt = DS_DATA;
          end else if (byte_tick) begin
            gap_nxt = gap_r + 6'h1;
            if (gap_nxt == (double_density ? `DSS_DAM_DD : `DSS_DAM_SD)) begin
              stat_nxt[`DSS_ST_SEEK] = 1'b1;
              busy_nxt = 1'b0;
              irq_nxt = 1'b1;
              st_nxt = DS_IDLE;
            end
          end
        end
        DS_DATA: begin
          if (rd_valid && bytes_r != 11'h0) begin
            dh_nxt = rd_byte;
            drq_nxt = 1'b1;
            bytes_nxt = bytes_r - 11'h1;
            if (drq_r && !data_rd) stat_nxt[`DSS_ST_LOST] = 1'b1;
          end
          if (data_end) begin
            if (!data_crc_ok || !cmd_r[4]) begin
              stat_nxt[`DSS_ST_CRC] = !data_crc_ok;
              busy_nxt = 1'b0;
              irq_nxt = 1'b1;
              st_nxt = DS_IDLE;
            end else begin
              sec_nxt = sec_r + 8'h1;
              idx_nxt = 3'h0;
              st_nxt = DS_IDSRCH;
              if (sec_nxt > `DSS_SPT) begin
                stat_nxt[`DSS_ST_SEEK] = 1'b1;
                busy_nxt = 1'b0;
                irq_nxt = 1'b1;
                st_nxt = DS_IDLE;
              end
            end
          end
        end
        default: st_nxt = DS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= DS_IDLE;
      {cmd_r, trk_r, sec_r, dat_r, dh_r, steps_r} <= '0;
      stat_r <= '0;
      {busy_r, irq_r, drq_r, step_r, dir_r, hld_r, sso_r, side_seen_r} <= '0;
      mrn_r <= 1'b1;
      cnt_r <= '0;
      idx_r <= '0;
      bytes_r <= '0;
      gap_r <= '0;
    end else begin
      st_r <= st_nxt;
      {cmd_r, trk_r, sec_r, dat_r, dh_r, steps_r} <=
        {cmd_nxt, trk_nxt, sec_nxt, dat_nxt, dh_nxt, steps_nxt};
      stat_r <= stat_nxt;
      {busy_r, irq_r, drq_r, step_r, dir_r, hld_r, sso_r, side_seen_r} <=
        {busy_nxt, irq_nxt, drq_nxt, step_nxt, dir_nxt, hld_nxt, sso_nxt, side_seen_nxt};
      mrn_r <= master_reset_n;
      cnt_r <= cnt_nxt;
      idx_r <= idx_nxt;
      bytes_r <= bytes_nxt;
      gap_r <= gap_nxt;
    end
  end

  assign busy = busy_r;
  assign completion_irq = irq_r;
  assign byte_request = drq_r;
  assign status = {stat_r, drq_r, busy_r};
  assign track_reg = trk_r;
  assign sector_reg = sec_r;
  assign data_reg = dat_r;
  assign data_holding_reg = dh_r;
  assign step_out = step_r;
  assign dir_out = dir_r;
  assign head_load_out = hld_r;
  assign side_select_out = sso_r;

  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_byte_in;
    st_r == DS_DATA && rd_valid && bytes_r != 11'h0;
  endsequence
  sequence s_unread;
    drq_r && !data_rd;
  endsequence
  AST_TYPE1_BUSY: assert property (cmd_wr && master_reset_n && !busy_r && !cmd_in[7]
    |=> busy_r) else $error("type 1 command did not set busy");
  AST_DONE_IRQ: assert property ($fell(busy_r) && master_reset_n && !$past(cmd_wr)
    |-> irq_r) else $error("busy cleared without interrupt");
  AST_NOT_READY: assert property (cmd_wr && master_reset_n && !busy_r
    && cmd_in[7:5] == 3'b100 && !drive_ready |=> irq_r && !busy_r)
    else $error("sector command ran without drive ready");
  AST_BYTE_OUT: assert property (s_byte_in |=> drq_r && dh_r == $past(rd_byte))
    else $error("assembled byte not handed to host");
  AST_LOST: assert property (s_byte_in and s_unread |=> stat_r[`DSS_ST_LOST])
    else $error("overrun not flagged as lost data");
  AST_DIR_STABLE: assert property (step_r && $past(step_r) |-> $stable(dir_r))
    else $error("direction moved during step pulse");
  AST_RESTORE_ZERO: assert property (st_r == DS_DECIDE && cmd_r[7:4] == 4'h0
    && !track_zero_in && master_reset_n && !cmd_wr && $stable(master_reset_n)
    |=> trk_r == 8'h0 ##1 st_r != DS_PULSE) else $error("restore missed track zero");
  AST_MR_RESTORE: assert property ($rose(master_reset_n) && !busy_r
    |=> busy_r && cmd_r == `DSS_MR_CMD) else $error("no restore after master reset");
  AST_DATA_CRC: assert property (st_r == DS_DATA && data_end && !data_crc_ok
    && master_reset_n && !cmd_wr |=> stat_r[`DSS_ST_CRC] && !busy_r)
    else $error("bad data CRC not terminating");
  AST_VERIFY_SEEK: assert property (st_r == DS_VERIFY && id_valid && id_crc_ok && !trk_ok
    && master_reset_n && !cmd_wr |=> stat_r[`DSS_ST_SEEK] && irq_r && !busy_r)
    else $error("verify mismatch not a seek error");
endmodule : dss_sequencer
`default_nettype wire

/* dss_drive_model.sv */
// drive mechanism and media stream model for the sequencer bench
`timescale 1ns/1ps
`default_nettype none
module dss_drive_model #(
  parameter int START_TRK = 3,
  parameter int SPT = 26
) (
  input wire logic clk,
  input wire logic step_out,
  input wire logic dir_out,
  input wire logic head_load_out,
  input wire logic [2:0] fault,
  input wire logic [7:0] data_seed,
  output logic track_zero_in,
  output logic head_settled_in,
  output logic index_pulse,
  output logic byte_tick,
  output logic id_valid,
  output logic [7:0] id_track,
  output logic [7:0] id_side,
  output logic [7:0] id_sector,
  output logic [1:0] id_len,
  output logic id_crc_ok,
  output logic dam_valid,
  output logic dam_deleted,
  output logic rd_valid,
  output logic [7:0] rd_byte,
  output logic data_end,
  output logic data_crc_ok,
  output logic [7:0] head_pos
);
  // ****************************************
  // head position and sector slots
  // ****************************************
  logic [8:0] slot_r = 9'h000;
  logic [7:0] sec_r = 8'h01;
  logic step_q = 1'b0;
  logic [7:0] pos_r = 8'(START_TRK);
  logic [6:0] k;
  // slot: id at 0, mark at 4, 128 bytes two cycles apart, end at 264
  always @(posedge clk) begin
    step_q <= step_out;
    head_settled_in <= head_load_out;
    if (step_out && !step_q) begin
      pos_r <= dir_out ? pos_r + 8'h01 : (pos_r == 8'h00 ? 8'h00 : pos_r - 8'h01);
    end
    slot_r <= (slot_r == 9'h10F) ? 9'h000 : slot_r + 9'h001;
    if (slot_r == 9'h10F) begin
      sec_r <= (sec_r == 8'(SPT)) ? 8'h01 : sec_r + 8'h01;
    end
  end
  assign head_pos = pos_r;
  assign track_zero_in = head_pos != 8'h00;
  assign k = 7'((slot_r - 9'h006) >> 1);
  assign byte_tick = slot_r[0];
  assign id_valid = slot_r == 9'h000;
  assign index_pulse = id_valid && sec_r == 8'h01;
  // released lines show the inverse so a stale sample cannot match
  assign id_track = id_valid ? head_pos + {7'h00, fault == 3'h2} : ~head_pos;
  assign id_side = id_valid ? 8'h00 : 8'hFF;
  assign id_sector = id_valid ? sec_r : ~sec_r;
  assign id_len = 2'h0;
  assign id_crc_ok = fault != 3'h1;
  assign dam_valid = slot_r == 9'h004 && fault != 3'h5;
  assign dam_deleted = fault == 3'h4;
  assign rd_valid = slot_r >= 9'h006 && slot_r <= 9'h104 && !slot_r[0];
  assign rd_byte = rd_valid ? data_seed ^ sec_r ^ {1'b0, k} : slot_r[7:0];
  assign data_end = slot_r == 9'h108;
  assign data_crc_ok = fault != 3'h3;
endmodule : dss_drive_model
`default_nettype wire

/* tb_disk_seek_and_sector_sequencer.sv */
// self-checking bench for the disk seek and sector sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_disk_seek_and_sector_sequencer;
  logic clk = 1'b0, reset = 1'b1, master_reset_n = 1'b1, cmd_wr = 1'b0, track_wr = 1'b0;
  logic sector_wr = 1'b0, data_wr = 1'b0, data_rd = 1'b0, drive_ready = 1'b1;
  logic double_density = 1'b0, rd_en = 1'b0, arm_r = 1'b0;
  logic [7:0] cmd_in = 8'h00, wr_data = 8'h00, data_seed = 8'h00, t;
  logic [2:0] fault = 3'h0;
  logic busy, completion_irq, byte_request, step_out, dir_out, head_load_out, side_select_out;
  logic [7:0] status, track_reg, sector_reg, data_reg, data_holding_reg, head_pos;
  logic track_zero_in, head_settled_in, index_pulse, byte_tick, id_valid, id_crc_ok;
  logic dam_valid, dam_deleted, rd_valid, data_end, data_crc_ok;
  logic [7:0] id_track, id_side, id_sector, rd_byte;
  logic [1:0] id_len;
  logic [31:0] exp_done[$];
  logic [7:0] exp_byte[$];
  int fail_count = 0, samples_checked = 0, done_count = 0;

  always #4 clk = ~clk;

  // short settle and rate counts keep the run small
  dss_sequencer #(.SETTLE_CYC(20), .RATE_CYC0(10), .RATE_CYC1(20), .RATE_CYC2(30),
    .RATE_CYC3(40)) dss_sequencer_i (.*);
  dss_drive_model dss_drive_model_i (.*);

  // ****************************************
  // compares and host tasks
  // ****************************************
  task automatic compare_done(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch status_track_sector_head expected %h seen %h", e, g);
    end
  endtask : compare_done

  task automatic compare_byte(input string what, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : compare_byte

  task automatic final_report;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic load(ref logic s, input logic [7:0] v);
    wr_data = v;
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask : load

  task automatic go(input logic [31:0] e);
    int n;
    n = done_count;
    exp_done.push_back(e);
    cyc(1);
    arm_r = 1'b1;
    for (int i = 0; i < 40000 && done_count == n; i++) cyc(1);
    if (done_count == n) begin
      fail_count++;
      $display("mismatch completion expected irq seen none");
      final_report();
    end
  endtask : go

  task automatic run(input logic [7:0] c, input logic [1:0] bh, input logic [31:0] e);
    cmd_in = c;
    cmd_wr = 1'b1;
    cyc(1);
    cmd_wr = 1'b0;
    compare_byte("busy_hld", {6'h00, bh}, {6'h00, busy, head_load_out & bh[0]});
    go(e);
  endtask : run

  task automatic rd(input logic [7:0] c, input logic [7:0] s, input int n,
    input logic [31:0] e);
    load(sector_wr, s);
    for (int j = 0; j < n; j++) exp_byte.push_back(data_seed ^ 8'(s + j / 128) ^ 8'(j % 128));
    rd_en = n > 0;
    run(c, 2'b11, e);
    cyc(4);
    compare_byte("bytes_left", 8'h00, 8'(exp_byte.size()));
  endtask : rd

  // completion watcher: a new command must pass one edge before it can complete
  always @(posedge clk) begin
    if (arm_r && completion_irq === 1'b1) begin
      arm_r = 1'b0;
      compare_done(exp_done.size() > 0 ? exp_done.pop_front() : 32'hXXXXXXXX,
        {status, track_reg, sector_reg, head_pos});
      done_count++;
    end
  end

  // host reader: skips the edge where its own read is still being taken
  always @(posedge clk) begin
    if (rd_en && byte_request === 1'b1 && data_rd === 1'b0) begin
      compare_byte("byte", exp_byte.size() > 0 ? exp_byte.pop_front() : 8'hXX,
        data_holding_reg);
      data_rd <= #1 1'b1;
    end else begin
      data_rd <= #1 1'b0;
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    void'($urandom(21627));
    data_seed = 8'($urandom);
    cyc(8);
    reset = 1'b0;
    cyc(2);
    master_reset_n = 1'b0;
    cyc(3);
    master_reset_n = 1'b1;
    go({8'h00, 8'h00, 8'h00, 8'h00});
    run(8'h50, 2'b10, {8'h00, 8'h01, 8'h00, 8'h01});
    run(8'h41, 2'b10, {8'h00, 8'h01, 8'h00, 8'h02});
    run(8'h32, 2'b10, {8'h00, 8'h02, 8'h00, 8'h03});
    run(8'h73, 2'b10, {8'h00, 8'h01, 8'h00, 8'h02});
    run(8'h00, 2'b10, {8'h00, 8'h00, 8'h00, 8'h00});
    t = 8'($urandom_range(20, 1));
    load(data_wr, t);
    run(8'h10, 2'b10, {8'h00, t, 8'h00, t});
    load(data_wr, 8'h02);
    run(8'h1C, 2'b11, {8'h00, 8'h02, 8'h00, 8'h02});
    fault = 3'h2;
    run(8'h54, 2'b10, {8'h10, 8'h03, 8'h00, 8'h03});
    // every ID CRC bad: verify keeps flagging CRC until the revolution limit
    fault = 3'h1;
    load(data_wr, 8'h03);
    run(8'h14, 2'b10, {8'h08, 8'h03, 8'h00, 8'h03});
    fault = 3'h0;
    load(track_wr, 8'h03);
    rd(8'h86, 8'h05, 128, {8'h00, 8'h03, 8'h05, 8'h03});
    fault = 3'h4;
    rd(8'h80, 8'h02, 128, {8'h20, 8'h03, 8'h02, 8'h03});
    fault = 3'h3;
    rd(8'h90, 8'h19, 128, {8'h08, 8'h03, 8'h19, 8'h03});
    fault = 3'h0;
    rd(8'h90, 8'h19, 256, {8'h10, 8'h03, 8'h1B, 8'h03});
    fault = 3'h5;
    rd(8'h80, 8'h07, 0, {8'h10, 8'h03, 8'h07, 8'h03});
    fault = 3'h0;
    rd(8'h80, 8'h01, 0, {8'h06, 8'h03, 8'h01, 8'h03});
    exp_byte.push_back(data_seed ^ 8'h01 ^ 8'h7F);
    rd_en = 1'b1;
    cyc(4);
    compare_byte("unread", 8'h00, 8'(exp_byte.size()));
    drive_ready = 1'b0;
    run(8'h80, 2'b00, {8'h80, 8'h03, 8'h01, 8'h03});
    final_report();
  end
endmodule : tb_disk_seek_and_sector_sequencer
`default_nettype wire
